// ==== hw/jtg_defs.svh ====
// Constants for the boundary-scan test logic
`ifndef JTG_DEFS_SVH
`define JTG_DEFS_SVH

//----------------------------------------
// Instruction register
//----------------------------------------
`define JTG_IR_W        4
`define JTG_OP_EXTEST   4'h0
`define JTG_OP_SAMPLE   4'h1
`define JTG_OP_IDCODE   4'h2
`define JTG_OP_HIGHZ    4'h3
`define JTG_OP_BYPASS   4'hf
`define JTG_IR_CAPTURE  4'h1

//----------------------------------------
// Identification word layout
//----------------------------------------
`define JTG_ID_W        32
`define JTG_ID_VER_MSB  31
`define JTG_ID_VER_LSB  28
`define JTG_ID_PART_MSB 27
`define JTG_ID_PART_LSB 12
`define JTG_ID_MFR_MSB  11
`define JTG_ID_MFR_LSB  1
`define JTG_ID_FIX_BIT  1'b1

//----------------------------------------
// Synchroniser and reset counts
//----------------------------------------
`define JTG_SYNC_STAGES 3
`define JTG_TLR_TMS_CNT 3'h5

`endif

// ==== hw/jtg_pkg.sv ====
// Types shared by the boundary-scan test logic
package jtg_pkg;

  //----------------------------------------
  // Controller states, one-hot
  //----------------------------------------
  typedef enum logic [15:0] {
    JTG_TLR  = 16'h0001,
    JTG_RTI  = 16'h0002,
    JTG_SDR  = 16'h0004,
    JTG_CDR  = 16'h0008,
    JTG_SHDR = 16'h0010,
    JTG_E1DR = 16'h0020,
    JTG_PDR  = 16'h0040,
    JTG_E2DR = 16'h0080,
    JTG_UDR  = 16'h0100,
    JTG_SIR  = 16'h0200,
    JTG_CIR  = 16'h0400,
    JTG_SHIR = 16'h0800,
    JTG_E1IR = 16'h1000,
    JTG_PIR  = 16'h2000,
    JTG_E2IR = 16'h4000,
    JTG_UIR  = 16'h8000
  } jtg_tap_state_e;

  //----------------------------------------
  // Data register selected by the instruction
  //----------------------------------------
  typedef enum logic [1:0] {
    JTG_SEL_BSR = 2'h0,
    JTG_SEL_ID  = 2'h1,
    JTG_SEL_BYP = 2'h2
  } jtg_dr_sel_e;

endpackage : jtg_pkg

// ==== hw/jtg_tap_if.sv ====
// Link between the sampling front end and the controller state machine
`timescale 1ns/1ps
`default_nettype none

interface jtg_tap_if;
  logic                    tck_rise;
  logic                    tck_fall;
  logic                    tms;
  logic                    trst;
  jtg_pkg::jtg_tap_state_e state;

  modport ctl (input tck_rise, input tms, input trst, output state);
  modport dat (output tck_rise, output tck_fall, output tms, output trst, input state);
endinterface : jtg_tap_if

`default_nettype wire

// ==== hw/jtg_tap_fsm.sv ====
// Test access port controller state machine
`timescale 1ns/1ps
`default_nettype none
`include "jtg_defs.svh"

module jtg_tap_fsm (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sampled test pins
  jtg_tap_if.ctl   tap
);

  typedef struct packed {
    jtg_pkg::jtg_tap_state_e state;
    logic [2:0]              ones;
  } jtg_fsm_s;

  jtg_fsm_s q;
  jtg_fsm_s d;

  function automatic jtg_pkg::jtg_tap_state_e nxt(input jtg_pkg::jtg_tap_state_e s, input logic m);
    case (s)
      jtg_pkg::JTG_TLR:  nxt = m ? jtg_pkg::JTG_TLR  : jtg_pkg::JTG_RTI;
      jtg_pkg::JTG_RTI:  nxt = m ? jtg_pkg::JTG_SDR  : jtg_pkg::JTG_RTI;
      jtg_pkg::JTG_SDR:  nxt = m ? jtg_pkg::JTG_SIR  : jtg_pkg::JTG_CDR;
      jtg_pkg::JTG_CDR:  nxt = m ? jtg_pkg::JTG_E1DR : jtg_pkg::JTG_SHDR;
      jtg_pkg::JTG_SHDR: nxt = m ? jtg_pkg::JTG_E1DR : jtg_pkg::JTG_SHDR;
      jtg_pkg::JTG_E1DR: nxt = m ? jtg_pkg::JTG_UDR  : jtg_pkg::JTG_PDR;
      jtg_pkg::JTG_PDR:  nxt = m ? jtg_pkg::JTG_E2DR : jtg_pkg::JTG_PDR;
      jtg_pkg::JTG_E2DR: nxt = m ? jtg_pkg::JTG_UDR  : jtg_pkg::JTG_SHDR;
      jtg_pkg::JTG_UDR:  nxt = m ? jtg_pkg::JTG_SDR  : jtg_pkg::JTG_RTI;
      jtg_pkg::JTG_SIR:  nxt = m ? jtg_pkg::JTG_TLR  : jtg_pkg::JTG_CIR;
      jtg_pkg::JTG_CIR:  nxt = m ? jtg_pkg::JTG_E1IR : jtg_pkg::JTG_SHIR;
      jtg_pkg::JTG_SHIR: nxt = m ? jtg_pkg::JTG_E1IR : jtg_pkg::JTG_SHIR;
      jtg_pkg::JTG_E1IR: nxt = m ? jtg_pkg::JTG_UIR  : jtg_pkg::JTG_PIR;
      jtg_pkg::JTG_PIR:  nxt = m ? jtg_pkg::JTG_E2IR : jtg_pkg::JTG_PIR;
      jtg_pkg::JTG_E2IR: nxt = m ? jtg_pkg::JTG_UIR  : jtg_pkg::JTG_SHIR;
      jtg_pkg::JTG_UIR:  nxt = m ? jtg_pkg::JTG_SDR  : jtg_pkg::JTG_RTI;
      default:           nxt = jtg_pkg::JTG_TLR;
    endcase
  endfunction : nxt

  //----------------------------------------
  // State update
  //----------------------------------------
  always_comb begin
    d = q;
    if (tap.trst) begin
      d.state = jtg_pkg::JTG_TLR;
      d.ones  = 3'h0;
    end else if (tap.tck_rise) begin
      d.state = nxt(q.state, tap.tms);
      if (!tap.tms) begin
        d.ones = 3'h0;
      end else if (q.ones != `JTG_TLR_TMS_CNT) begin
        d.ones = q.ones + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q.state <= jtg_pkg::JTG_TLR;
      q.ones  <= 3'h0;
    end else begin
      q <= d;
    end
  end

  assign tap.state = q.state;

  tms_reset_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.ones == `JTG_TLR_TMS_CNT |-> q.state == jtg_pkg::JTG_TLR)
    else $error("five high mode-select edges did not reach test-logic-reset");

  trst_reset_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    tap.trst |=> q.state == jtg_pkg::JTG_TLR)
    else $error("test reset did not reach test-logic-reset");

endmodule : jtg_tap_fsm

`default_nettype wire

// ==== hw/jtg_test_logic.sv ====
// Boundary-scan data registers, instruction decode and pin control
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "jtg_defs.svh"

module jtg_test_logic #(
  parameter int unsigned PIN_N      = 4,
  parameter logic [3:0]  ID_VERSION = 4'h6,    // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'h0001, // Arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h001   // Arbitrary value
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Test access pins
  input  wire logic             test_clock_pin,
  input  wire logic             tms_pin,
  input  wire logic             tdi_pin,
  input  wire logic             trst_n_pin,
  output logic                  tdo_out,
  output logic                  tdo_oe,
  // Functional core side
  input  wire logic [PIN_N-1:0] core_out,
  input  wire logic [PIN_N-1:0] core_oe,
  input  wire logic [PIN_N-1:0] pad_in,
  // Device pins
  output logic      [PIN_N-1:0] pin_out,
  output logic      [PIN_N-1:0] pin_oe
);

  //------------------------------------------------------------
  // Local shapes
  //------------------------------------------------------------
  localparam int unsigned BSR_W  = 2 * PIN_N;
  localparam int unsigned TCK_I  = 0;
  localparam int unsigned TMS_I  = 1;
  localparam int unsigned TDI_I  = 2;
  localparam int unsigned TRST_I = 3;

  localparam logic [`JTG_ID_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, `JTG_ID_FIX_BIT};

  typedef struct packed {
    logic [3:0][`JTG_SYNC_STAGES-1:0] sync;
    logic [3:0]                       filt;
    logic                             tck_rise;
    logic                             tck_fall;
    logic [`JTG_IR_W-1:0]             ir_sh;
    logic [`JTG_IR_W-1:0]             ir_cur;
    logic                             byp;
    logic [`JTG_ID_W-1:0]             id_sh;
    logic [BSR_W-1:0]                 bsr_sh;
    logic [BSR_W-1:0]                 bsr_upd;
    logic                             tdo;
    logic                             tdo_oe;
    logic [PIN_N-1:0]                 pin_out;
    logic [PIN_N-1:0]                 pin_oe;
  } jtg_core_s;

  jtg_core_s  q;
  jtg_core_s  d;
  logic [3:0] raw;

  jtg_tap_if tap ();

  //------------------------------------------------------------
  // Controller
  //------------------------------------------------------------
  jtg_tap_fsm u_fsm (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tap     (tap.ctl)
  );

  assign tap.tck_rise = q.tck_rise;
  assign tap.tck_fall = q.tck_fall;
  assign tap.tms      = q.filt[TMS_I];
  // Filtered reset reads low out of system reset, so the controller waits until the pin is seen high
  assign tap.trst     = ~q.filt[TRST_I];

  //------------------------------------------------------------
  // Instruction decode
  //------------------------------------------------------------
  // Every code outside the listed ones falls to bypass, the safest path
  function automatic jtg_pkg::jtg_dr_sel_e dr_sel(input logic [`JTG_IR_W-1:0] op);
    case (op)
      `JTG_OP_EXTEST: dr_sel = jtg_pkg::JTG_SEL_BSR;
      `JTG_OP_SAMPLE: dr_sel = jtg_pkg::JTG_SEL_BSR;
      `JTG_OP_IDCODE: dr_sel = jtg_pkg::JTG_SEL_ID;
      default:        dr_sel = jtg_pkg::JTG_SEL_BYP;
    endcase
  endfunction : dr_sel

  jtg_pkg::jtg_dr_sel_e sel;
  assign sel = dr_sel(q.ir_cur);

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  assign raw = {trst_n_pin, tdi_pin, tms_pin, test_clock_pin};

  always_comb begin
    d = q;
    // Pins are slow against ref_clk; a level counts once stages two and three agree
    for (int i = 0; i < 4; i++) begin
      d.sync[i] = {q.sync[i][`JTG_SYNC_STAGES-2:0], raw[i]};
      if (q.sync[i][1] == q.sync[i][2]) begin
        d.filt[i] = q.sync[i][2];
      end
    end
    d.tck_rise = d.filt[TCK_I] & ~q.filt[TCK_I];
    d.tck_fall = ~d.filt[TCK_I] & q.filt[TCK_I];

    // Rising test-clock edge: capture and shift, using the state before the edge
    if (q.tck_rise) begin
      case (tap.state)
        jtg_pkg::JTG_CIR: begin
          d.ir_sh = `JTG_IR_CAPTURE;
        end
        jtg_pkg::JTG_SHIR: begin
          d.ir_sh = {q.filt[TDI_I], q.ir_sh[`JTG_IR_W-1:1]};
        end
        jtg_pkg::JTG_CDR: begin
          case (sel)
            jtg_pkg::JTG_SEL_BSR: d.bsr_sh = {core_out, pad_in};
            jtg_pkg::JTG_SEL_ID:  d.id_sh  = ID_WORD;
            default:              d.byp    = 1'b0;
          endcase
        end
        jtg_pkg::JTG_SHDR: begin
          // Only the selected register moves; the others hold
          case (sel)
            jtg_pkg::JTG_SEL_BSR: d.bsr_sh = {q.filt[TDI_I], q.bsr_sh[BSR_W-1:1]};
            jtg_pkg::JTG_SEL_ID:  d.id_sh  = {q.filt[TDI_I], q.id_sh[`JTG_ID_W-1:1]};
            default:              d.byp    = q.filt[TDI_I];
          endcase
        end
        default: begin
        end
      endcase
    end

    // Falling test-clock edge: drive the serial output and latch updates
    if (q.tck_fall) begin
      d.tdo_oe = 1'b0;
      case (tap.state)
        jtg_pkg::JTG_SHIR: begin
          d.tdo    = q.ir_sh[0];
          d.tdo_oe = 1'b1;
        end
        jtg_pkg::JTG_SHDR: begin
          d.tdo_oe = 1'b1;
          case (sel)
            jtg_pkg::JTG_SEL_BSR: d.tdo = q.bsr_sh[0];
            jtg_pkg::JTG_SEL_ID:  d.tdo = q.id_sh[0];
            default:              d.tdo = q.byp;
          endcase
        end
        jtg_pkg::JTG_UIR: begin
          d.ir_cur = q.ir_sh;
        end
        jtg_pkg::JTG_UDR: begin
          if (sel == jtg_pkg::JTG_SEL_BSR) begin
            d.bsr_upd = q.bsr_sh;
          end
        end
        default: begin
        end
      endcase
    end

    // Reset state always leaves the identification word selected
    if (tap.state == jtg_pkg::JTG_TLR) begin
      d.ir_cur = `JTG_OP_IDCODE;
    end

    // Pin control follows only the latched instruction, never the scan traffic
    case (q.ir_cur)
      `JTG_OP_EXTEST: begin
        d.pin_out = q.bsr_upd[BSR_W-1:PIN_N];
        d.pin_oe  = '1;
      end
      `JTG_OP_HIGHZ: begin
        d.pin_out = core_out;
        d.pin_oe  = '0;
      end
      default: begin
        d.pin_out = core_out;
        d.pin_oe  = core_oe;
      end
    endcase
  end

  //------------------------------------------------------------
  // State registers
  //------------------------------------------------------------
  // Only the instruction leaves reset non-zero, so identification is ready at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q        <= '0;
      q.ir_cur <= `JTG_OP_IDCODE;
    end else begin
      q <= d;
    end
  end

  assign tdo_out = q.tdo;
  assign tdo_oe  = q.tdo_oe;
  assign pin_out = q.pin_out;
  assign pin_oe  = q.pin_oe;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  bypass_capture_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_rise && tap.state == jtg_pkg::JTG_CDR && sel == jtg_pkg::JTG_SEL_BYP |=> q.byp == 1'b0)
    else $error("bypass stage not cleared at capture");

  bypass_stage_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_rise && tap.state == jtg_pkg::JTG_SHDR && sel == jtg_pkg::JTG_SEL_BYP
    |=> q.byp == $past(q.filt[TDI_I]))
    else $error("bypass stage did not take serial input");

  id_capture_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_rise && tap.state == jtg_pkg::JTG_CDR && sel == jtg_pkg::JTG_SEL_ID
    |=> q.id_sh[`JTG_ID_VER_MSB:`JTG_ID_VER_LSB] == ID_VERSION
        && q.id_sh[`JTG_ID_PART_MSB:`JTG_ID_PART_LSB] == ID_PART
        && q.id_sh[`JTG_ID_MFR_MSB:`JTG_ID_MFR_LSB] == ID_MAKER
        && q.id_sh[0] == 1'b1)
    else $error("identification word captured with wrong layout");

  ir_capture_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_rise && tap.state == jtg_pkg::JTG_CIR |=> q.ir_sh[1:0] == 2'b01)
    else $error("instruction capture pattern wrong");

  ir_shift_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_rise && tap.state == jtg_pkg::JTG_SHIR
    |=> q.ir_sh[3] == $past(q.filt[TDI_I]) && q.ir_sh[2:0] == $past(q.ir_sh[3:1]))
    else $error("instruction bits not shifted");

  idcode_reset_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    tap.state == jtg_pkg::JTG_TLR |=> q.ir_cur == `JTG_OP_IDCODE)
    else $error("identification not selected after test reset");

  id_output_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_fall && tap.state == jtg_pkg::JTG_SHDR && sel == jtg_pkg::JTG_SEL_ID
    |=> q.tdo == $past(q.id_sh[0]) && q.tdo_oe)
    else $error("identification bit not on serial output");

  highz_pins_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.ir_cur == `JTG_OP_HIGHZ |=> q.pin_oe == '0)
    else $error("pins driven under high-impedance code");

  func_pins_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.ir_cur != `JTG_OP_EXTEST && q.ir_cur != `JTG_OP_HIGHZ
    |=> q.pin_out == $past(core_out) && q.pin_oe == $past(core_oe))
    else $error("functional pins disturbed by test logic");

  extest_drive_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.ir_cur == `JTG_OP_EXTEST |=> q.pin_out == $past(q.bsr_upd[BSR_W-1:PIN_N]) && q.pin_oe == '1)
    else $error("boundary register not driving pins");

  //------------------------------------------------------------
  // Serial path and update checks
  //------------------------------------------------------------
  bypass_output_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_fall && tap.state == jtg_pkg::JTG_SHDR && sel == jtg_pkg::JTG_SEL_BYP
    |=> q.tdo == $past(q.byp) && q.tdo_oe)
    else $error("bypass stage not on serial output");

  ir_output_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_fall && tap.state == jtg_pkg::JTG_SHIR
    |=> q.tdo == $past(q.ir_sh[0]) && q.tdo_oe)
    else $error("instruction bit not on serial output");

  // The pad sample is taken as already registered; pad_in has no synchroniser here
  bsr_capture_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_rise && tap.state == jtg_pkg::JTG_CDR && sel == jtg_pkg::JTG_SEL_BSR
    |=> q.bsr_sh == $past({core_out, pad_in}))
    else $error("boundary register missed the pin sample");

  bsr_update_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_fall && tap.state == jtg_pkg::JTG_UDR && sel == jtg_pkg::JTG_SEL_BSR
    |=> q.bsr_upd == $past(q.bsr_sh))
    else $error("boundary update latch not loaded");

  // Registers off the scan path must not move while another one is scanned
  bsr_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_rise && tap.state == jtg_pkg::JTG_SHDR && sel != jtg_pkg::JTG_SEL_BSR
    |=> q.bsr_sh == $past(q.bsr_sh))
    else $error("unselected boundary register moved");

  id_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_rise && tap.state == jtg_pkg::JTG_SHDR && sel != jtg_pkg::JTG_SEL_ID
    |=> q.id_sh == $past(q.id_sh))
    else $error("unselected identification register moved");

  ir_update_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_fall && tap.state == jtg_pkg::JTG_UIR |=> q.ir_cur == $past(q.ir_sh))
    else $error("instruction not latched at update");

  // Serial output is released outside the shift states so the chain is not fought over
  tdo_release_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.tck_fall && tap.state != jtg_pkg::JTG_SHIR && tap.state != jtg_pkg::JTG_SHDR
    |=> !q.tdo_oe)
    else $error("serial output driven outside shift");

endmodule : jtg_test_logic

`default_nettype wire

// ==== testbench/jtg_ctl_model.sv ====
// Behavioural boundary-scan controller driving the test pins
`timescale 1ns/1ps
`default_nettype none

module jtg_ctl_model (
  // Clock
  input  wire logic ref_clk,
  // Test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic oe_err;

  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
    trst_n = 1'b1;
    oe_err = 1'b0;
  end

  //----------------------------------------
  // Test clock cycles, 8 ref_clk each
  //----------------------------------------
  // Output lags the pin fall by several cycles, so it is taken just before the next fall
  task automatic cyc(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(posedge ref_clk);
    #1 tck = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 o = tdo;
    tck = 1'b0;
  endtask : cyc

  // Five high mode-select clocks, then idle
  task automatic tap_reset();
    logic o;
    repeat (5) cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
  endtask : tap_reset

  task automatic trst_pulse();
    logic o;
    trst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 trst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 cyc(1'b0, 1'b0, o);
  endtask : trst_pulse

  // From idle: capture, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    cyc(1'b1, 1'b0, o);
    if (ir) cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], o);
      dout[i] = o;
      if (tdo_oe !== 1'b1) oe_err = 1'b1;
    end
    cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
  endtask : scan
endmodule : jtg_ctl_model

`default_nettype wire

// ==== testbench/jtg_test_logic_tb.sv ====
// Self-checking bench for the boundary-scan test logic
`timescale 1ns/1ps
`default_nettype none

module jtg_test_logic_tb;
  localparam int          PN  = 4;
  localparam logic [3:0]  VER = 4'h9;    // Arbitrary value
  localparam logic [15:0] PRT = 16'h5a3c; // Arbitrary value
  localparam logic [10:0] MKR = 11'h2b6;  // Arbitrary value
  localparam logic [31:0] ID_EXP = {VER, PRT, MKR, 1'b1};

  logic          ref_clk;
  logic          rst_n;
  logic          tck;
  logic          tms;
  logic          tdi;
  logic          trst_n;
  logic          tdo;
  logic          tdo_oe;
  logic [PN-1:0] core_out;
  logic [PN-1:0] core_oe;
  logic [PN-1:0] pad_in;
  logic [PN-1:0] pin_out;
  logic [PN-1:0] pin_oe;
  logic [PN-1:0] upd;
  logic [31:0]   sv;
  logic [31:0]   din;
  logic [31:0]   cap;
  logic [3:0]    code;
  int            len;
  int            err_total;
  int            total_checks;
  int            cycles;

  jtg_test_logic #(.PIN_N(PN), .ID_VERSION(VER), .ID_PART(PRT), .ID_MAKER(MKR)) u_jtg_test_logic (
    .ref_clk(ref_clk), .rst_n(rst_n), .test_clock_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
    .trst_n_pin(trst_n), .tdo_out(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
    .pad_in(pad_in), .pin_out(pin_out), .pin_oe(pin_oe));

  jtg_ctl_model u_jtg_ctl_model (
    .ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Whole run needs about 7600 cycles; a hang stops well past that
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end

  //----------------------------------------
  // Reference model and checking
  //----------------------------------------
  function automatic logic [31:0] exp_scan(int l, logic [31:0] c, logic [31:0] d);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = (i < l) ? c[i] : d[i-l];
    return r;
  endfunction : exp_scan

  function automatic logic [31:0] exp_pins(logic [3:0] c, logic [PN-1:0] u);
    if (c == 4'h0) return 32'({u, {PN{1'b1}}});
    if (c == 4'h3) return 32'({core_out, {PN{1'b0}}});
    return 32'({core_out, core_oe});
  endfunction : exp_pins

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  //----------------------------------------
  // Main sequence
  //----------------------------------------
  initial begin
    rst_n    = 1'b0;
    core_out = '0;
    core_oe  = '0;
    pad_in   = '0;
    void'($urandom(32'h756afae2));
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 u_jtg_ctl_model.tap_reset();
    u_jtg_ctl_model.scan(1'b0, 32, $urandom, sv);
    chk(sv, ID_EXP);
    upd = '0;
    // Sample goes first so that its preload is seen under external test
    for (int i = 0; i < 16; i++) begin
      code     = 4'(i) ^ 4'h1;
      core_out = PN'($urandom);
      core_oe  = PN'($urandom);
      pad_in   = PN'($urandom);
      u_jtg_ctl_model.scan(1'b1, 4, {28'h0, code}, sv);
      chk(sv, 32'h1);
      repeat (4) @(posedge ref_clk);
      #1 chk(32'({pin_out, pin_oe}), exp_pins(code, upd));
      din = $urandom;
      len = (code < 4'h2) ? 2 * PN : (code == 4'h2) ? 32 : 1;
      cap = (code < 4'h2) ? 32'({core_out, pad_in}) : (code == 4'h2) ? ID_EXP : 32'h0;
      u_jtg_ctl_model.scan(1'b0, 32, din, sv);
      chk(sv, exp_scan(len, cap, din));
      if (code < 4'h2) upd = din[31:32-PN];
      repeat (4) @(posedge ref_clk);
      #1 chk(32'({pin_out, pin_oe}), exp_pins(code, upd));
    end
    u_jtg_ctl_model.trst_pulse();
    u_jtg_ctl_model.scan(1'b0, 32, $urandom, sv);
    chk(sv, ID_EXP);
    u_jtg_ctl_model.scan(1'b1, 4, 32'hf, sv);
    u_jtg_ctl_model.tap_reset();
    u_jtg_ctl_model.scan(1'b0, 32, $urandom, sv);
    chk(sv, ID_EXP);
    chk(32'(u_jtg_ctl_model.oe_err), 32'h0);
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk(32'({pin_out, pin_oe}), 32'h0);
    rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 u_jtg_ctl_model.tap_reset();
    u_jtg_ctl_model.scan(1'b0, 32, $urandom, sv);
    chk(sv, ID_EXP);
    finish_test();
  end
endmodule : jtg_test_logic_tb

`default_nettype wire
